// [src/bandgap_trim_map.vh]
// register indices, field positions, reset values and hold-off timing for the bandgap trim bank
// assumes a word-addressed bus where the byte address is four times the index
`ifndef BANDGAP_TRIM_MAP_VH
`define BANDGAP_TRIM_MAP_VH

`define IDX_LEVEL_TRIM 8'hd0
`define IDX_CURVATURE_TRIM 8'hd1
`define IDX_TRIM_CTRL 8'hd2
`define IDX_LEVEL_HOLDOFF 8'hd3
`define IDX_CURV_HOLDOFF 8'hd4
`define IDX_TRIM_STATUS 8'hd5

`define LEVEL_CODE_MSB 5
`define LEVEL_RESERVED_BIT 6
`define LEVEL_LEGACY_EN_BIT 7
`define CTRL_REF_EN_BIT 0
`define CTRL_STEP_EN_BIT 1
`define STAT_LEVEL_BUSY_BIT 0
`define STAT_CURV_BUSY_BIT 1
`define STAT_CURV_LEGAL_BIT 2
`define STAT_REF_EN_BIT 3

`define LEVEL_TRIM_RESET 6'h00
`define CURV_TRIM_RESET 8'h00
`define TRIM_CTRL_RESET 2'h0

`define CLK_PERIOD_NS 50
`define LEVEL_HOLDOFF_NS_PER_UF 1200
`define CURV_HOLDOFF_NS_PER_UF 3000
`define LEVEL_HOLDOFF_CYC ((`LEVEL_HOLDOFF_NS_PER_UF + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define CURV_HOLDOFF_CYC ((`CURV_HOLDOFF_NS_PER_UF + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)

`endif

// [src/trim_stepper.v]
// one trim field: applied code, target and hold-off counter between single-code steps
// assumes targets handed in are legal codes for the chosen coding
`timescale 1ns/10ps
`default_nettype none

module trim_stepper #(
  parameter W = 6,
  parameter THERMO = 0
) (
  input wire mclk,
  input wire nrst,
  input wire clkEn,
  input wire stepEn,
  input wire load,
  input wire [W-1:0] loadVal,
  input wire [15:0] holdoff,
  output reg [W-1:0] code_q,
  output reg busy_q
);

  reg [W-1:0] target_q;
  reg [15:0] wait_q;
  reg [W-1:0] stepUp;
  reg [W-1:0] stepDown;
  wire goUp;
  wire atTarget;

  assign goUp = (target_q > code_q);
  assign atTarget = (target_q == code_q);

  always @*
  begin
    if (THERMO != 0)
    begin
      // one more or one fewer filled bit keeps a thermometer code legal
      stepUp = {code_q[W-2:0], 1'b1};
      stepDown = {1'b0, code_q[W-1:1]};
    end
    else
    begin
      stepUp = code_q + {{(W-1){1'b0}}, 1'b1};
      stepDown = code_q - {{(W-1){1'b0}}, 1'b1};
    end
  end

  always @(posedge mclk or negedge nrst)
  begin
    if (!nrst)
    begin
      code_q <= {W{1'b0}};
      target_q <= {W{1'b0}};
      wait_q <= 16'h0000;
      busy_q <= 1'b0;
    end
    else if (clkEn)
    begin
      if (load)
      begin
        target_q <= loadVal;
        if (!stepEn)
        begin
          code_q <= loadVal;
          wait_q <= 16'h0000;
        end
        busy_q <= stepEn && (loadVal != code_q);
      end
      else if (stepEn && !atTarget)
      begin
        if (wait_q == 16'h0000)
        begin
          // single code per step, then hold off so the regulator catches up
          code_q <= goUp ? stepUp : stepDown;
          wait_q <= holdoff;
          busy_q <= 1'b1;
        end
        else
        begin
          wait_q <= wait_q - 16'h0001;
          busy_q <= 1'b1;
        end
      end
      else
      begin
        if (wait_q != 16'h0000)
          wait_q <= wait_q - 16'h0001;
        busy_q <= stepEn && !atTarget;
      end
    end
  end

endmodule

`default_nettype wire

// [src/bandgap_trim_calibration.v]
// bandgap trim register bank with optional single-step trim sequencer, Avalon-MM slave
// assumes one clock, word-addressed Avalon-MM master that holds requests until waitrequest is low
//
// Chosen here: the Avalon-MM interface to the registers.
`timescale 1ns/10ps
`default_nettype none
`include "bandgap_trim_map.vh"

module bandgap_trim_calibration (
  input wire mclk,
  input wire nrst,
  input wire clkEn,
  input wire [7:0] address,
  input wire read,
  input wire write,
  input wire [31:0] writedata,
  input wire [3:0] byteenable,
  output reg [31:0] readdata,
  output reg waitrequest,
  output wire [5:0] levelTrimCode,
  output wire [7:0] curvatureTrimCode,
  output reg [5:0] brownoutTrimCode,
  output reg refEnable,
  output reg regulatorAltRef,
  output reg adcRefReady
);

  // the cycle counts are integer arithmetic; cut to the 16-bit counter width on purpose
  localparam integer LEVEL_HOLDOFF_INT = `LEVEL_HOLDOFF_CYC;
  localparam integer CURV_HOLDOFF_INT = `CURV_HOLDOFF_CYC;
  localparam [15:0] LEVEL_HOLDOFF_DEF = LEVEL_HOLDOFF_INT[15:0];
  localparam [15:0] CURV_HOLDOFF_DEF = CURV_HOLDOFF_INT[15:0];

  reg refEn_q;
  reg stepEn_q;
  reg [15:0] levelHoldoff_q;
  reg [15:0] curvHoldoff_q;
  reg [31:0] rdData_d;
  wire levelBusy;
  wire curvBusy;
  wire commit;
  wire laneLow;
  wire levelLoad;
  wire curvLoad;
  wire [7:0] curvTarget;
  wire curvLegal;

  // fill every bit below the highest set bit, giving the nearest legal thermometer code above
  function [7:0] fill_down;
    input [7:0] v;
    reg [7:0] f;
    begin
      f = v;
      f = f | {1'b0, f[7:1]};
      f = f | {2'b00, f[7:2]};
      f = f | {4'h0, f[7:4]};
      fill_down = f;
    end
  endfunction

  // a legal thermometer code plus one is a power of two, or it is all ones
  function is_thermo;
    input [7:0] v;
    reg [8:0] p;
    begin
      p = {1'b0, v} + 9'h001;
      is_thermo = ((p & (p - 9'h001)) == 9'h000);
    end
  endfunction

  // a request is answered one cycle after it is seen; the write lands when waitrequest is low
  assign commit = write && !waitrequest;
  assign laneLow = byteenable[0];
  assign levelLoad = commit && laneLow && (address == `IDX_LEVEL_TRIM);
  assign curvLoad = commit && laneLow && (address == `IDX_CURVATURE_TRIM);

  // in step mode an illegal curvature value would make the walk oscillate, so round it up
  assign curvTarget = stepEn_q ? fill_down(writedata[7:0]) : writedata[7:0];
  assign curvLegal = is_thermo(curvatureTrimCode);

  trim_stepper #(
    .W(6),
    .THERMO(0)
  ) levelStep (
    .mclk(mclk),
    .nrst(nrst),
    .clkEn(clkEn),
    .stepEn(stepEn_q),
    .load(levelLoad),
    .loadVal(writedata[`LEVEL_CODE_MSB:0]),
    .holdoff(levelHoldoff_q),
    .code_q(levelTrimCode),
    .busy_q(levelBusy)
  );
  // binary code, 000000 lowest level up to 111111 highest, one uniform step per code

  trim_stepper #(
    .W(8),
    .THERMO(1)
  ) curvStep (
    .mclk(mclk),
    .nrst(nrst),
    .clkEn(clkEn),
    .stepEn(stepEn_q),
    .load(curvLoad),
    .loadVal(curvTarget),
    .holdoff(curvHoldoff_q),
    .code_q(curvatureTrimCode),
    .busy_q(curvBusy)
  );
  // stepping fills or drains ones from bit zero, zeros puts the peak hottest

  always @*
  begin
    rdData_d = 32'h00000000;
    if (address == `IDX_LEVEL_TRIM)
    begin
      // bits seven and six read zero and ignore writes
      rdData_d[`LEVEL_CODE_MSB:0] = levelTrimCode;
    end
    else if (address == `IDX_CURVATURE_TRIM)
    begin
      rdData_d[7:0] = curvatureTrimCode;
    end
    else if (address == `IDX_TRIM_CTRL)
    begin
      rdData_d[`CTRL_REF_EN_BIT] = refEn_q;
      rdData_d[`CTRL_STEP_EN_BIT] = stepEn_q;
    end
    else if (address == `IDX_LEVEL_HOLDOFF)
    begin
      rdData_d[15:0] = levelHoldoff_q;
    end
    else if (address == `IDX_CURV_HOLDOFF)
    begin
      rdData_d[15:0] = curvHoldoff_q;
    end
    else if (address == `IDX_TRIM_STATUS)
    begin
      rdData_d[`STAT_LEVEL_BUSY_BIT] = levelBusy;
      rdData_d[`STAT_CURV_BUSY_BIT] = curvBusy;
      rdData_d[`STAT_CURV_LEGAL_BIT] = curvLegal;
      rdData_d[`STAT_REF_EN_BIT] = refEn_q;
    end
    else
    begin
      rdData_d = 32'h00000000;
    end
  end

  // bus handshake: waitrequest idles high, drops for one cycle per request
  always @(posedge mclk or negedge nrst)
  begin
    if (!nrst)
    begin
      waitrequest <= 1'b1;
      readdata <= 32'h00000000;
    end
    else if (clkEn)
    begin
      if ((read || write) && waitrequest)
      begin
        waitrequest <= 1'b0;
        if (read)
          readdata <= rdData_d;
      end
      else
      begin
        waitrequest <= 1'b1;
      end
    end
  end

  // control and hold-off registers; hold-off resets to the 1 uF figures
  always @(posedge mclk or negedge nrst)
  begin
    if (!nrst)
    begin
      refEn_q <= 1'b0;
      stepEn_q <= 1'b0;
      levelHoldoff_q <= LEVEL_HOLDOFF_DEF;
      curvHoldoff_q <= CURV_HOLDOFF_DEF;
    end
    else if (clkEn && commit)
    begin
      if (address == `IDX_TRIM_CTRL)
      begin
        if (laneLow)
        begin
          // reference enable lives here, apart from any converter enable
          refEn_q <= writedata[`CTRL_REF_EN_BIT];
          stepEn_q <= writedata[`CTRL_STEP_EN_BIT];
        end
      end
      else if (address == `IDX_LEVEL_HOLDOFF)
      begin
        if (laneLow)
          levelHoldoff_q[7:0] <= writedata[7:0];
        if (byteenable[1])
          levelHoldoff_q[15:8] <= writedata[15:8];
      end
      else if (address == `IDX_CURV_HOLDOFF)
      begin
        if (laneLow)
          curvHoldoff_q[7:0] <= writedata[7:0];
        if (byteenable[1])
          curvHoldoff_q[15:8] <= writedata[15:8];
      end
    end
  end

  // analog-facing controls, registered so nothing glitches into the reference
  always @(posedge mclk or negedge nrst)
  begin
    if (!nrst)
    begin
      brownoutTrimCode <= `LEVEL_TRIM_RESET;
      refEnable <= 1'b0;
      regulatorAltRef <= 1'b1;
      adcRefReady <= 1'b0;
    end
    else if (clkEn)
    begin
      // the brown-out threshold follows the same code; it reacts fast, the regulator slowly,
      // which is why the stepper exists
      brownoutTrimCode <= levelTrimCode;
      refEnable <= refEn_q;
      // alternate reference only ever feeds the regulator, never the converters
      regulatorAltRef <= !refEn_q;
      adcRefReady <= refEn_q;
    end
  end

endmodule

`default_nettype wire

// [test/trim_bank_sva.sv]
// assertions on the trim bank ports
// assumes binding onto the top module, one clock, clkEn held high by the bench except in t_freeze
`timescale 1ns/10ps
`default_nettype none
module trim_bank_sva (
  input wire logic mclk,
  input wire logic nrst,
  input wire logic clkEn,
  input wire logic [7:0] address,
  input wire logic read,
  input wire logic write,
  input wire logic [31:0] readdata,
  input wire logic waitrequest,
  input wire logic [5:0] levelTrimCode,
  input wire logic [7:0] curvatureTrimCode,
  input wire logic [5:0] brownoutTrimCode,
  input wire logic refEnable,
  input wire logic regulatorAltRef,
  input wire logic adcRefReady
);
  default clocking @(posedge mclk); endclocking
  default disable iff (!nrst);
  wire logic ack = !waitrequest;
  wire logic wrCtrl = write && ack && address == 8'hd2;
  a_wait_one: assert property ((read || write) && waitrequest && clkEn |=> ack)
    else $error("no ack after one wait cycle");
  a_ack_single: assert property (ack |=> !ack)
    else $error("ack held too long");
  a_level_read: assert property (read && ack && address == 8'hd0 |-> readdata == {26'h0, $past(levelTrimCode)})
    else $error("level readback wrong");
  a_curv_read: assert property (read && ack && address == 8'hd1 |-> readdata == {24'h0, $past(curvatureTrimCode)})
    else $error("curvature readback wrong");
  a_bod_follow: assert property (clkEn |=> brownoutTrimCode == $past(levelTrimCode))
    else $error("brownout trim lags");
  a_alt_ref: assert property ($stable(refEnable) [*2] |-> regulatorAltRef != refEnable)
    else $error("alternate reference select wrong");
  a_adc_ref: assert property ($stable(refEnable) [*2] |-> adcRefReady == refEnable)
    else $error("adc served without bandgap");
  a_ref_cause: assert property ($changed(refEnable) |-> $past(wrCtrl) || $past(wrCtrl, 2))
    else $error("reference enable moved without ctrl write");
endmodule
bind bandgap_trim_calibration trim_bank_sva i_trim_bank_sva (.mclk(mclk), .nrst(nrst), .clkEn(clkEn),
  .address(address), .read(read), .write(write), .readdata(readdata), .waitrequest(waitrequest),
  .levelTrimCode(levelTrimCode), .curvatureTrimCode(curvatureTrimCode), .brownoutTrimCode(brownoutTrimCode),
  .refEnable(refEnable), .regulatorAltRef(regulatorAltRef), .adcRefReady(adcRefReady));
`default_nettype wire

// [test/tb.sv]
// bench for the trim bank: Avalon bus task, one task per scenario
// assumes the register map header and the bound checker
`timescale 1ns/10ps
`default_nettype none
`include "bandgap_trim_map.vh"
module tb;
  logic mclk = 1'h0, nrst = 1'h0, clkEn = 1'h1, read = 1'h0, write = 1'h0;
  logic [7:0] address = 8'h00;
  logic [31:0] writedata = 32'h0, readdata, rdVal;
  logic waitrequest, refEnable, regulatorAltRef, adcRefReady;
  logic [5:0] levelTrimCode, brownoutTrimCode;
  logic [7:0] curvatureTrimCode;
  int errorCnt = 0, checkCount = 0;
  always #25 mclk = ~mclk;
  bandgap_trim_calibration i_bandgap_trim_calibration (.mclk(mclk), .nrst(nrst), .clkEn(clkEn),
    .address(address), .read(read), .write(write), .writedata(writedata), .byteenable(4'hf),
    .readdata(readdata), .waitrequest(waitrequest), .levelTrimCode(levelTrimCode),
    .curvatureTrimCode(curvatureTrimCode), .brownoutTrimCode(brownoutTrimCode), .refEnable(refEnable),
    .regulatorAltRef(regulatorAltRef), .adcRefReady(adcRefReady));
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checkCount++;
    if (seen !== exp)
    begin
      errorCnt++;
      $display("MISMATCH %0t seen %h want %h", $time, seen, exp);
    end
  endtask
  // request held until waitrequest is sampled low; only the watchdog ends a hang
  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
    write <= wr;
    read <= !wr;
    address <= a;
    writedata <= d;
    @(posedge mclk);
    while (waitrequest !== 1'h0)
      @(posedge mclk);
    rdVal = readdata;
    write <= 1'h0;
    read <= 1'h0;
    @(posedge mclk);
  endtask
  task automatic t_reset;
    check({regulatorAltRef, adcRefReady, curvatureTrimCode, levelTrimCode}, 16'h8000);
    bus(1'h1, 8'hff, 32'hffffffff);
    bus(1'h0, 8'hff, 32'h0);
    check(rdVal, 32'h0);
  endtask
  task automatic t_curv;
    logic [7:0] c;
    for (int i = 0; i < 9; i++)
    begin
      c = 8'hff >> (8 - i);
      bus(1'h1, `IDX_CURVATURE_TRIM, {24'h0, c});
      bus(1'h0, `IDX_TRIM_STATUS, 32'h0);
      check({rdVal[`STAT_CURV_LEGAL_BIT], curvatureTrimCode}, {1'h1, c});
    end
    bus(1'h1, `IDX_CURVATURE_TRIM, 32'ha5);
    bus(1'h0, `IDX_TRIM_STATUS, 32'h0);
    check({rdVal[`STAT_CURV_LEGAL_BIT], curvatureTrimCode}, 32'h0a5);
    bus(1'h1, `IDX_CURVATURE_TRIM, 32'h0);
  endtask
  task automatic t_level;
    bus(1'h1, `IDX_LEVEL_TRIM, 32'hff);
    bus(1'h0, `IDX_LEVEL_TRIM, 32'h0);
    check(rdVal, 32'h3f);
    check(brownoutTrimCode, 32'h3f);
    bus(1'h1, `IDX_LEVEL_TRIM, 32'h0);
  endtask
  task automatic t_ref;
    bus(1'h1, `IDX_TRIM_CTRL, 32'h1);
    repeat (2) @(posedge mclk);
    check({refEnable, regulatorAltRef, adcRefReady}, 32'h5);
    bus(1'h1, `IDX_TRIM_CTRL, 32'h2);
    repeat (2) @(posedge mclk);
    check({refEnable, regulatorAltRef, adcRefReady}, 32'h2);
    bus(1'h0, `IDX_LEVEL_HOLDOFF, 32'h0);
    check(rdVal, 32'h2);
    bus(1'h0, `IDX_TRIM_CTRL, 32'h0);
    check(rdVal, 32'h2);
  endtask
  // clkEn low freezes the handshake and the trims; a held write completes once it returns
  task automatic t_freeze;
    bus(1'h1, `IDX_TRIM_CTRL, 32'h0);
    clkEn <= 1'h0;
    write <= 1'h1;
    address <= `IDX_LEVEL_TRIM;
    writedata <= 32'h15;
    repeat (4) @(posedge mclk);
    check({waitrequest, levelTrimCode}, 32'h44);
    clkEn <= 1'h1;
    @(posedge mclk);
    while (waitrequest !== 1'h0)
      @(posedge mclk);
    write <= 1'h0;
    @(posedge mclk);
    check(levelTrimCode, 32'h15);
  endtask
  // step mode: each change is one legal code, at least hold-off+1 cycles apart
  task automatic walk(input logic [7:0] idx, input logic [7:0] tgt);
    logic [7:0] prev, cur;
    int gap, n;
    bus(1'h1, idx, {24'h0, tgt});
    bus(1'h0, `IDX_TRIM_STATUS, 32'h0);
    check(rdVal[1:0] != 2'h0, 32'h1);
    gap = 9;
    prev = idx[0] ? curvatureTrimCode : {2'h0, levelTrimCode};
    for (n = 0; n < 200 && prev !== tgt; n++)
    begin
      @(posedge mclk);
      gap++;
      cur = idx[0] ? curvatureTrimCode : {2'h0, levelTrimCode};
      if (cur !== prev)
      begin
        check(cur, idx[0] ? {prev[6:0], 1'h1} : prev + 8'h01);
        check(gap > 2, 32'h1);
        gap = 0;
      end
      prev = cur;
    end
    check(prev, tgt);
    bus(1'h0, `IDX_TRIM_STATUS, 32'h0);
    check(rdVal[1:0], 32'h0);
  endtask
  task automatic endOfTest;
    $display("errors %0d checks %0d", errorCnt, checkCount);
    if (errorCnt == 0 && checkCount > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  initial
  begin
    repeat (12) @(posedge mclk);
    nrst <= 1'h1;
    @(posedge mclk);
    t_reset;
    t_curv;
    t_level;
    bus(1'h1, `IDX_LEVEL_HOLDOFF, 32'h2);
    bus(1'h1, `IDX_CURV_HOLDOFF, 32'h2);
    t_ref;
    walk(`IDX_LEVEL_TRIM, 8'h04);
    walk(`IDX_CURVATURE_TRIM, 8'h07);
    t_freeze;
    endOfTest;
  end
  // whole run needs some 160 cycles; this allows about 4000
  initial
  begin
    #200000;
    errorCnt++;
    endOfTest;
  end
endmodule
`default_nettype wire
